// ---- core/upch_mem.sv ----
// Slot memory: one code and one data field per slot and direction.
// Assumes the user never writes and reads the same entry in one cycle.
`timescale 1ns/1ps
module upch_mem #(parameter int unsigned AW = 6)
(
    input wire logic clk_i,
    input wire logic rst_i,
    upch_mem_if.mem mp
);
    localparam int unsigned DEPTH = 2 ** AW;
    logic [3:0] code_q [DEPTH];
    logic [7:0] data_q [DEPTH];

    // Codes clear at reset so that no slot is driven before setup.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                code_q[i] <= upch_pkg::CODE_FREE;
            end
        end
        else if (mp.wr_en && mp.wr_code_en)
        begin
            code_q[mp.wr_addr] <= mp.wr_code;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (mp.wr_en && mp.wr_data_en)
        begin
            data_q[mp.wr_addr] <= mp.wr_data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mp.ra_data <= '0;
            mp.rb_data <= '0;
        end
        else
        begin
            mp.ra_data <= {code_q[mp.ra_addr], data_q[mp.ra_addr]};
            mp.rb_data <= {code_q[mp.rb_addr], data_q[mp.rb_addr]};
        end
    end
endmodule : upch_mem

// ---- core/upch_mem_if.sv ----
// Bundle between the channel logic and the slot memory.
// Assumes one write port and two registered read ports.
`timescale 1ns/1ps
interface upch_mem_if #(parameter int unsigned AW = 6);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic wr_code_en;
    logic wr_data_en;
    logic [3:0] wr_code;
    logic [7:0] wr_data;
    logic [AW-1:0] ra_addr;
    logic [11:0] ra_data;
    logic [AW-1:0] rb_addr;
    logic [11:0] rb_data;

    modport user
    (
        output wr_en, wr_addr, wr_code_en, wr_data_en, wr_code, wr_data,
        output ra_addr, rb_addr,
        input ra_data, rb_data
    );
    modport mem
    (
        input wr_en, wr_addr, wr_code_en, wr_data_en, wr_code, wr_data,
        input ra_addr, rb_addr,
        output ra_data, rb_data
    );
endinterface : upch_mem_if

// ---- core/upch_pkg.sv ----
// Shared constants, types and decode helpers for the processor channel block.
// Assumes a single 100 MHz clock domain and an APB register port.
package upch_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam int BUSY_BIT = 0;
    localparam int ADDR_DIR_BIT = 7;
    localparam int CTRL_RD_BIT = 7;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************************************
    // Slot codes and control values
    // ****************************************************************
    localparam logic [3:0] CODE_UP = 4'h9;
    localparam logic [3:0] CODE_FREE = 4'h0;
    localparam logic [2:0] CTRL_CODE_GRP = 3'h7;
    localparam logic [6:0] CTRL_DATA_OP = 7'h48;

    // ****************************************************************
    // Bit positions inside a slot at which the engine acts
    // ****************************************************************
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_PF_DOWN = 3'h2;
    localparam logic [2:0] BIT_LATCH_DOWN = 3'h4;
    localparam logic [2:0] BIT_LATCH_UP = 3'h6;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [1:0]
    {
        UPCH_IDLE = 2'b00,
        UPCH_WRITE = 2'b01,
        UPCH_READ = 2'b10,
        UPCH_CAPT = 2'b11
    } upch_op_e;

    typedef enum logic [2:0]
    {
        UPCH_R_NONE = 3'b000,
        UPCH_R_DATA = 3'b001,
        UPCH_R_ADDR = 3'b010,
        UPCH_R_CTRL = 3'b011,
        UPCH_R_STAT = 3'b100
    } upch_reg_e;

    // True for control values that touch the code field.
    function automatic logic upch_is_code_op(input logic [7:0] c);
        return c[6:4] == CTRL_CODE_GRP;
    endfunction : upch_is_code_op

    // True for control values that touch only the data field.
    function automatic logic upch_is_data_op(input logic [7:0] c);
        return c[6:0] == CTRL_DATA_OP;
    endfunction : upch_is_data_op

endpackage : upch_pkg

// ---- core/upch_sync.sv ----
// Three-stage pin synchroniser; a change counts once stages two and three
// agree. Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module upch_sync #(parameter int unsigned W = 3)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q_o <= '0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_o <= (s2_q & s3_q) | (q_o & (s2_q ^ s3_q));
        end
    end
endmodule : upch_sync

// ---- core/upch_top.sv ----
// Processor channel access to the configurable serial interface slots.
// Assumes an APB master, a slot bit clock much slower than clk_i and a
// frame sync pulse marking bit 0 of slot 0.
//
// Functional notes
// - Code 1001 makes a slot a processor channel.
// - Slot byte exchanged with that slot's data field.
// - Channels always span the full eight-bit slot.
// - Downstream byte repeats every frame, no interrupt.
// - Upstream byte refreshed every frame, readable anytime.
// - Control 79h stores code 1001 plus data.
// - Control 48h writes data, code left alone.
// - Control C8h reads data after busy clears.
// - Control F0h returns code in low nibble.
// - Control 70h sets code 0000, channel cancelled.
`timescale 1ns/1ps
module upch_top #(
    parameter int unsigned SLOT_W = 5,
    parameter int unsigned PADDR_W = 12
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [PADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic ser_fsync_i,
    input wire logic ser_bclk_i,
    input wire logic ser_rxd_i,
    output logic ser_txd_o,
    output logic ser_txd_oe_o
);
    localparam int unsigned AW = SLOT_W + 1;
    localparam int unsigned PW = SLOT_W + 3;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    upch_mem_if #(.AW(AW)) mif ();
    logic [2:0] pin_f;

    upch_mem #(.AW(AW)) u_mem
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mp(mif)
    );

    upch_sync #(.W(3)) u_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ser_fsync_i, ser_bclk_i, ser_rxd_i}),
        .q_o(pin_f)
    );

    // ****************************************************************
    // APB slave
    // ****************************************************************
    function automatic upch_pkg::upch_reg_e reg_sel(
        input logic [PADDR_W-1:0] a
    );
        upch_pkg::upch_reg_e s;
        s = upch_pkg::UPCH_R_NONE;
        if (a == PADDR_W'(upch_pkg::OFF_DATA))
            s = upch_pkg::UPCH_R_DATA;
        if (a == PADDR_W'(upch_pkg::OFF_ADDR))
            s = upch_pkg::UPCH_R_ADDR;
        if (a == PADDR_W'(upch_pkg::OFF_CTRL))
            s = upch_pkg::UPCH_R_CTRL;
        if (a == PADDR_W'(upch_pkg::OFF_STAT))
            s = upch_pkg::UPCH_R_STAT;
        return s;
    endfunction : reg_sel

    logic [7:0] data_q;
    logic [7:0] addr_q;
    logic [7:0] ctrl_q;
    logic busy_q;
    upch_pkg::upch_op_e op_q;
    logic [AW-1:0] op_addr_q;
    logic [7:0] op_ctrl_q;
    logic [31:0] rd_mux;
    logic setup;
    logic access_done;
    logic wr_data;
    logic wr_ctrl;
    logic accept;

    assign setup = psel_i & ~penable_i;
    assign access_done = psel_i & penable_i & pready_o;
    assign wr_data = access_done & pwrite_i
        & (reg_sel(paddr_i) == upch_pkg::UPCH_R_DATA);
    assign wr_ctrl = access_done & pwrite_i
        & (reg_sel(paddr_i) == upch_pkg::UPCH_R_CTRL);
    // A new control write is ignored while an access is still running.
    assign accept = wr_ctrl & ~busy_q
        & (upch_pkg::upch_is_code_op(pwdata_i[7:0])
        | upch_pkg::upch_is_data_op(pwdata_i[7:0]));

    always_comb
    begin
        rd_mux = '0;
        unique case (reg_sel(paddr_i))
            upch_pkg::UPCH_R_DATA: rd_mux[7:0] = data_q;
            upch_pkg::UPCH_R_ADDR: rd_mux[7:0] = addr_q;
            upch_pkg::UPCH_R_CTRL: rd_mux[7:0] = ctrl_q;
            upch_pkg::UPCH_R_STAT: rd_mux[upch_pkg::BUSY_BIT] = busy_q;
            upch_pkg::UPCH_R_NONE: rd_mux = '0;
        endcase
    end

    // No wait state: the answer is ready in the first access cycle.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end
        else
        begin
            pready_o <= setup;
            pslverr_o <= setup
                & (reg_sel(paddr_i) == upch_pkg::UPCH_R_NONE);
            prdata_o <= setup ? rd_mux : '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_q <= upch_pkg::RST_BYTE;
        end
        else if (access_done && pwrite_i
            && reg_sel(paddr_i) == upch_pkg::UPCH_R_ADDR)
        begin
            addr_q <= pwdata_i[7:0];
        end
    end

    // ****************************************************************
    // Indirect access sequencer
    // ****************************************************************
    logic eng_wr_q;
    logic [AW-1:0] eng_addr_q;
    logic [7:0] eng_byte_q;
    logic host_wr;
    logic [7:0] capt;

    assign host_wr = (op_q == upch_pkg::UPCH_WRITE) & ~eng_wr_q;
    assign capt = upch_pkg::upch_is_code_op(op_ctrl_q)
        ? {4'h0, mif.ra_data[11:8]} : mif.ra_data[7:0];

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            op_q <= upch_pkg::UPCH_IDLE;
            busy_q <= 1'b0;
            op_addr_q <= '0;
            op_ctrl_q <= upch_pkg::RST_BYTE;
            ctrl_q <= upch_pkg::RST_BYTE;
        end
        else
        begin
            unique case (op_q)
                upch_pkg::UPCH_IDLE:
                begin
                    if (accept)
                    begin
                        busy_q <= 1'b1;
                        ctrl_q <= pwdata_i[7:0];
                        op_ctrl_q <= pwdata_i[7:0];
                        op_addr_q <= {addr_q[upch_pkg::ADDR_DIR_BIT],
                            addr_q[SLOT_W-1:0]};
                        op_q <= pwdata_i[upch_pkg::CTRL_RD_BIT]
                            ? upch_pkg::UPCH_READ
                            : upch_pkg::UPCH_WRITE;
                    end
                end
                upch_pkg::UPCH_WRITE:
                begin
                    if (!eng_wr_q)
                    begin
                        busy_q <= 1'b0;
                        op_q <= upch_pkg::UPCH_IDLE;
                    end
                end
                upch_pkg::UPCH_READ: op_q <= upch_pkg::UPCH_CAPT;
                upch_pkg::UPCH_CAPT:
                begin
                    busy_q <= 1'b0;
                    op_q <= upch_pkg::UPCH_IDLE;
                end
            endcase
        end
    end

    // Read results win over a bus write that lands in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_q <= upch_pkg::RST_BYTE;
        end
        else if (op_q == upch_pkg::UPCH_CAPT)
        begin
            data_q <= capt;
        end
        else if (wr_data)
        begin
            data_q <= pwdata_i[7:0];
        end
    end

    // Engine writes take the port first; a host write waits one cycle.
    assign mif.wr_en = eng_wr_q | host_wr;
    assign mif.wr_addr = eng_wr_q ? eng_addr_q : op_addr_q;
    assign mif.wr_code_en = ~eng_wr_q
        & upch_pkg::upch_is_code_op(op_ctrl_q);
    assign mif.wr_data_en = 1'b1;
    assign mif.wr_code = op_ctrl_q[3:0];
    assign mif.wr_data = eng_wr_q ? eng_byte_q : data_q;
    assign mif.ra_addr = op_addr_q;

    // ****************************************************************
    // Serial slot engine
    // ****************************************************************
    logic bclk_d_q;
    logic rise;
    logic [PW-1:0] pos_q;
    logic [PW-1:0] next_pos;
    logic [2:0] cur_bit;
    logic [SLOT_W-1:0] cur_slot;
    logic [7:0] tx_sh_q;
    logic [7:0] rx_sh_q;
    logic [7:0] pre_data_q;
    logic pre_en_q;
    logic up_match_q;
    logic [AW-1:0] rb_addr_q;

    assign rise = pin_f[1] & ~bclk_d_q;
    assign next_pos = pin_f[2] ? '0 : PW'(pos_q + 1'b1);
    assign cur_bit = next_pos[2:0];
    assign cur_slot = next_pos[PW-1:3];
    assign mif.rb_addr = rb_addr_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bclk_d_q <= 1'b0;
            pos_q <= '0;
        end
        else
        begin
            bclk_d_q <= pin_f[1];
            if (rise)
            begin
                pos_q <= next_pos;
            end
        end
    end

    // Downstream: a processor channel drives its data byte, MSB first,
    // for the whole slot in every frame.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ser_txd_o <= 1'b0;
            ser_txd_oe_o <= 1'b0;
            tx_sh_q <= '0;
        end
        else if (rise)
        begin
            if (cur_bit == upch_pkg::BIT_FIRST)
            begin
                ser_txd_o <= pre_data_q[7] & pre_en_q;
                tx_sh_q <= {pre_data_q[6:0], 1'b0} & {8{pre_en_q}};
                ser_txd_oe_o <= pre_en_q;
            end
            else
            begin
                ser_txd_o <= tx_sh_q[7];
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // Memory lookups: next downstream slot, then this upstream slot.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rb_addr_q <= '0;
            pre_data_q <= '0;
            pre_en_q <= 1'b0;
            up_match_q <= 1'b0;
        end
        else if (rise)
        begin
            if (cur_bit == upch_pkg::BIT_PF_DOWN)
            begin
                rb_addr_q <= {1'b0, SLOT_W'(cur_slot + 1'b1)};
            end
            if (cur_bit == upch_pkg::BIT_LATCH_DOWN)
            begin
                pre_data_q <= mif.rb_data[7:0];
                pre_en_q <= mif.rb_data[11:8] == upch_pkg::CODE_UP;
                rb_addr_q <= {1'b1, cur_slot};
            end
            if (cur_bit == upch_pkg::BIT_LATCH_UP)
            begin
                up_match_q <= mif.rb_data[11:8] == upch_pkg::CODE_UP;
            end
        end
    end

    // Upstream: the whole received byte replaces the data field.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_sh_q <= '0;
            eng_wr_q <= 1'b0;
            eng_addr_q <= '0;
            eng_byte_q <= '0;
        end
        else
        begin
            eng_wr_q <= 1'b0;
            if (rise)
            begin
                rx_sh_q <= {rx_sh_q[6:0], pin_f[0]};
                if (cur_bit == upch_pkg::BIT_LAST)
                begin
                    eng_wr_q <= up_match_q;
                    eng_addr_q <= {1'b1, cur_slot};
                    eng_byte_q <= {rx_sh_q[6:0], pin_f[0]};
                end
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_busy_sets: assert property (accept |=> busy_q)
        else $error("busy not set after accepted control write");
    chk_busy_ends: assert property ($rose(busy_q) |-> ##[1:3] !busy_q)
        else $error("access busy held too long");
    chk_code_nibble: assert property (
        op_q == upch_pkg::UPCH_CAPT && upch_pkg::upch_is_code_op(op_ctrl_q)
        |=> data_q[7:4] == 4'h0 && data_q[3:0] == $past(mif.ra_data[11:8]))
        else $error("code read did not land in low nibble");
    chk_data_read: assert property (
        op_q == upch_pkg::UPCH_CAPT && upch_pkg::upch_is_data_op(op_ctrl_q)
        |=> data_q == $past(mif.ra_data[7:0]) && !busy_q)
        else $error("data read result wrong");
    chk_create_code: assert property (
        accept && pwdata_i[7:0] == 8'h79 |-> ##[1:3] (mif.wr_en
        && mif.wr_code_en && mif.wr_code == upch_pkg::CODE_UP))
        else $error("channel create did not store its code");
    chk_cancel_code: assert property (
        accept && pwdata_i[7:0] == 8'h70 |-> ##[1:3] (mif.wr_en
        && mif.wr_code_en && mif.wr_code == upch_pkg::CODE_FREE))
        else $error("channel cancel did not clear its code");
    chk_data_only: assert property (
        mif.wr_en && op_q == upch_pkg::UPCH_WRITE
        && upch_pkg::upch_is_data_op(op_ctrl_q) |-> !mif.wr_code_en)
        else $error("data write touched the code field");
    chk_up_store: assert property (
        eng_wr_q |-> $past(up_match_q) && !mif.wr_code_en
        && mif.wr_addr[AW-1] && mif.wr_data == eng_byte_q)
        else $error("upstream store malformed");
    chk_slot_whole: assert property (
        rise && cur_bit != upch_pkg::BIT_FIRST |=> $stable(ser_txd_oe_o))
        else $error("drive enable changed inside a slot");
    chk_slot_code: assert property (
        rise && cur_bit == upch_pkg::BIT_FIRST
        |=> ser_txd_oe_o == $past(pre_en_q))
        else $error("drive enable not taken from slot code");
    chk_apb_ready: assert property (setup |=> pready_o ##1 !pready_o)
        else $error("ready not a single access-phase pulse");

    cov_create: cover property (accept && pwdata_i[7:0] == 8'h79);
    cov_code_read: cover property (
        op_q == upch_pkg::UPCH_CAPT && upch_pkg::upch_is_code_op(op_ctrl_q));
    cov_up_store: cover property (eng_wr_q);
    cov_tx_slot: cover property ($rose(ser_txd_oe_o));
    cov_wr_stall: cover property (op_q == upch_pkg::UPCH_WRITE && eng_wr_q);

endmodule : upch_top

// ---- testbench/tb_upch_top.sv ----
// Self-checking bench: APB master tasks, serial partner model, random
// slot data from a fixed seed. Assumes the package register offsets.
`timescale 1ns/1ps
module tb_upch_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic bclk;
    logic fsync;
    logic rxd;
    logic txd;
    logic txd_oe;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 95;
    logic [31:0] rdat;
    logic err;
    logic [7:0] dval;
    logic [7:0] dval2;
    logic [4:0] s;
    logic [7:0] ups [2];

    always #5 clk_i = ~clk_i;

    upch_top upch_top_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .ser_fsync_i(fsync), .ser_bclk_i(bclk),
        .ser_rxd_i(rxd), .ser_txd_o(txd), .ser_txd_oe_o(txd_oe));

    upch_ser_model upch_ser_model_inst (.bclk_o(bclk), .fsync_o(fsync),
        .rxd_o(rxd), .txd_i(txd), .txd_oe_i(txd_oe));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One APB transfer, entered just after a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {4'h0, a};
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
            n_mismatch++;
        rdat = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    // Indirect access; read operations leave the result in rdat.
    task automatic mem_op(input logic [7:0] a, input logic [7:0] c,
        input logic [7:0] d);
        int n;
        n = 0;
        apb(1'b1, upch_pkg::OFF_DATA, {24'h00_0000, d});
        apb(1'b1, upch_pkg::OFF_ADDR, {24'h00_0000, a});
        apb(1'b1, upch_pkg::OFF_CTRL, {24'h00_0000, c});
        rdat = 32'h0000_0001;
        while (rdat[0] !== 1'b0 && n < 20)
        begin
            apb(1'b0, upch_pkg::OFF_STAT, 32'h0000_0000);
            n++;
        end
        if (n == 20)
            n_mismatch++;
        if (c[7])
            apb(1'b0, upch_pkg::OFF_DATA, 32'h0000_0000);
    endtask : mem_op

    function automatic logic [31:0] code_word(input logic [3:0] c);
        return {28'h000_0000, c};
    endfunction : code_word

    task automatic wait_frames(input int n);
        repeat (n) @(upch_ser_model_inst.frame_cnt);
        @(posedge clk_i);
    endtask : wait_frames

    task automatic check_up();
        for (int i = 0; i < 2; i++)
        begin
            mem_op(ups[i], 8'hc8, 8'h00);
            check("up data", rdat,
                {24'h00_0000, upch_ser_model_inst.up_byte[ups[i][4:0]]});
        end
    endtask : check_up

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        apb(1'b0, upch_pkg::OFF_STAT, 32'h0000_0000);
        check("busy", {31'h0, rdat[0]}, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check("unmapped err", {31'h0, err}, 32'h0000_0001);
        check("unmapped data", rdat, 32'h0000_0000);
        s = 5'(($random(seed) & 15) + 1);
        dval = 8'($random(seed));
        dval2 = 8'($random(seed));
        ups[0] = 8'h9f;
        ups[1] = 8'h80 | 8'($random(seed) & 15);
        mem_op({3'h0, s}, 8'h79, dval);
        mem_op(8'h00, 8'h79, ~dval2);
        mem_op(8'h00, 8'h48, dval2);
        mem_op({3'h0, s}, 8'hf0, 8'h00);
        check("code s", rdat, code_word(upch_pkg::CODE_UP));
        mem_op(8'h00, 8'hf0, 8'h00);
        check("code 0", rdat, code_word(upch_pkg::CODE_UP));
        mem_op(8'h00, 8'hc8, 8'h00);
        check("data 0", rdat, {24'h00_0000, dval2});
        check("mapped err", {31'h0, err}, 32'h0000_0000);
        apb(1'b1, upch_pkg::OFF_CTRL, 32'h0000_0012);
        apb(1'b0, upch_pkg::OFF_CTRL, 32'h0000_0000);
        check("ctrl", rdat, 32'h0000_00c8);
        for (int i = 0; i < 2; i++)
        begin
            upch_ser_model_inst.up_byte[ups[i][4:0]] = 8'($random(seed));
            mem_op(ups[i], 8'h79, 8'hff);
        end
        wait_frames(2);
        check("tx s", {24'h0, upch_ser_model_inst.down_byte[s]},
            {24'h0, dval});
        check("oe s", {31'h0, upch_ser_model_inst.oe_seen[s]}, 32'h1);
        check("tx 0", {24'h0, upch_ser_model_inst.down_byte[0]},
            {24'h0, dval2});
        check("oe 31", {31'h0, upch_ser_model_inst.oe_seen[31]}, 32'h0);
        check_up();
        for (int i = 0; i < 2; i++)
            upch_ser_model_inst.up_byte[ups[i][4:0]] = 8'($random(seed));
        mem_op({3'h0, s}, 8'h70, 8'h00);
        mem_op({3'h0, s}, 8'hf0, 8'h00);
        check("code free", rdat, code_word(upch_pkg::CODE_FREE));
        wait_frames(2);
        check("oe off", {31'h0, upch_ser_model_inst.oe_seen[s]}, 32'h0);
        check("oe 0", {31'h0, upch_ser_model_inst.oe_seen[0]}, 32'h1);
        check_up();
        conclude();
    end
endmodule : tb_upch_top

// ---- testbench/upch_ser_model.sv ----
// Partner model of the serial subscribers: bit clock, frame sync, upstream
// bytes out; downstream bytes and drive enable captured for every slot.
// Assumes the block drives txd about five clk cycles after a bclk rise.
`timescale 1ns/1ps
module upch_ser_model
(
    output logic bclk_o,
    output logic fsync_o,
    output logic rxd_o,
    input wire logic txd_i,
    input wire logic txd_oe_i
);
    logic [7:0] up_byte [32];
    logic [7:0] down_byte [32];
    logic oe_seen [32];
    logic [7:0] sh;
    logic oe_acc;
    int frame_cnt;

    // ****************************************************************
    // Frame generator
    // ****************************************************************
    // Halves of 80 ns leave the synchroniser ample margin; txd is
    // sampled 75 ns after the rise, inside the bit that it belongs to.
    initial
    begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
        rxd_o = 1'b0;
        sh = 8'h00;
        frame_cnt = 0;
        foreach (up_byte[i])
        begin
            up_byte[i] = 8'h00;
            down_byte[i] = 8'h00;
            oe_seen[i] = 1'b0;
        end
        forever
        begin
            for (int s = 0; s < 32; s++)
            begin
                oe_acc = 1'b0;
                for (int b = 0; b < 8; b++)
                begin
                    fsync_o = (s == 0 && b == 0);
                    rxd_o = up_byte[s][7 - b];
                    #80 bclk_o = 1'b1;
                    #75 sh = {sh[6:0], txd_i};
                    oe_acc = oe_acc | txd_oe_i;
                    #5 bclk_o = 1'b0;
                end
                down_byte[s] = sh;
                oe_seen[s] = oe_acc;
            end
            frame_cnt++;
        end
    end
endmodule : upch_ser_model
